// *** logic/dbc_consts.svh ***
/*
 * Register indices, bit positions, reset values and step sizes of the
 * transfer byte counter and read data port block.
 * Assumes: included by bare name; byte address of a register is 4 * index.
 */
`ifndef DBC_CONSTS_SVH
`define DBC_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define DBC_IDX_STAT     8'h40
`define DBC_IDX_MASK     8'h41
`define DBC_IDX_CFG      8'h71
`define DBC_IDX_CTL      8'h72
`define DBC_IDX_CNT3     8'h78
`define DBC_IDX_CNT2     8'h79
`define DBC_IDX_CNT1     8'h7a
`define DBC_IDX_CNT0     8'h7b
`define DBC_IDX_RDLO     8'h7c
`define DBC_IDX_RDHI     8'h7d

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DBC_CTL_GO       0
`define DBC_CTL_STOP     1
`define DBC_CTL_DIR      3
`define DBC_CTL_CLR      4
`define DBC_CTL_RUN      7
`define DBC_CFG_ACTIVE   3
`define DBC_CFG_ACKMODE  6
`define DBC_CFG_FREE_RUN_SELECT  7
`define DBC_STAT_CMP     0
`define DBC_STAT_OVF     1

// ----------------------------------------------------------------
// Reset values and steps
// ----------------------------------------------------------------
`define DBC_CNT_RST      32'h0000_0000
`define DBC_STEP_WORD    2'h2
`define DBC_ADDR_LOW     2'h0
`define DBC_ADDR_TOP     2'h0

`endif

// *** logic/dbc_pkg.sv ***
/*
 * Types shared by the byte counter block: transfer state and the
 * packed state records of each module.
 * Assumes: compiled before every other file of the block.
 */
package dbc_pkg;

    // Transfer state of the channel
    typedef enum logic {
        XFER_IDLE,
        XFER_RUN
    } dbc_xfer_e;

    // Whole state of the top module
    typedef struct packed {
        dbc_xfer_e   xfer;
        logic        free_run;
        logic        ack_mode;
        logic        active;
        logic        dir;
        logic [1:0]  stat;
        logic [1:0]  mask;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        fifo_pop;
        logic        ack_prev;
    } dbc_top_s;

    // State of the counter
    typedef struct packed {
        logic [31:0] cnt;
    } dbc_cnt_s;

    // State of the pin synchroniser
    typedef struct packed {
        logic [1:0] ff;
    } dbc_sync_s;

endpackage

// *** logic/dbc_cnt_if.sv ***
/*
 * Control and status bundle between the channel logic and its counter.
 * Assumes: both ends run on the same clock.
 */
`timescale 1ns/100ps

interface dbc_cnt_if;
    logic [3:0]  load_en;
    logic [7:0]  load_data;
    logic        clear;
    logic        dec;
    logic        inc;
    logic [1:0]  step;
    logic [31:0] count;
    logic        wrap;

    modport ctl (output load_en, output load_data, output clear, output dec, output inc, output step,
                 input count, input wrap);
    modport cnt (input load_en, input load_data, input clear, input dec, input inc, input step,
                 output count, output wrap);
endinterface

// *** logic/dbc_sync.sv ***
/*
 * Two flip-flop synchroniser for the external acknowledge pin.
 * Assumes: the pin is asynchronous to i_clk_sys; only the second stage is read.
 */
`timescale 1ns/100ps

module dbc_sync
    import dbc_pkg::*;
(
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_ce,
    // Pin and synchronised level
    input  wire logic i_pin,
    output logic      o_level
);
    import dbc_pkg::*;

    dbc_sync_s q;
    dbc_sync_s d;

    // ----------------------------------------------------------------
    // Shift chain
    // ----------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.ff = {q.ff[0], i_pin};
    end

    // Frozen while the clock enable is low
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            q <= '0;
        else if (i_ce)
            q <= d;
    end

    assign o_level = q.ff[1];  // Second stage only

endmodule // dbc_sync

// *** logic/dbc_counter.sv ***
/*
 * 32-bit transfer byte counter: byte-wise load, clear, count down and
 * count up with wrap-around.
 * Assumes: the controller never asks for inc and dec together.
 */
`timescale 1ns/100ps
`include "dbc_consts.svh"

module dbc_counter
    import dbc_pkg::*;
(
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_ce,
    // Control bundle
    dbc_cnt_if.cnt    cif
);
    import dbc_pkg::*;

    dbc_cnt_s    q;
    dbc_cnt_s    d;
    logic [32:0] sum;

    // ----------------------------------------------------------------
    // Next count
    // ----------------------------------------------------------------
    always_comb
    begin
        d   = q;
        sum = {1'b0, q.cnt} + {31'h0, cif.step};
        if (cif.clear)
            d.cnt = `DBC_CNT_RST;                                // RULE15
        else if (cif.inc)
            d.cnt = sum[31:0];                                   // RULE4 RULE6
        else if (cif.dec)
            d.cnt = q.cnt - {30'h0, cif.step};                   // RULE2
        // Software byte writes win over a beat in the same cycle
        for (int b = 0; b < 4; b++)
        begin
            if (cif.load_en[b])
                d.cnt[b*8 +: 8] = cif.load_data;                 // RULE1 RULE16
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            q.cnt <= `DBC_CNT_RST;                               // RULE12
        else if (i_ce)
            q <= d;
    end

    assign cif.count = q.cnt;
    assign cif.wrap  = cif.inc & ~cif.clear & sum[32];           // Carry out of bit 31

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    AST_CNT_DOWN: assert property (i_ce && cif.dec && !cif.inc && !cif.clear && cif.load_en == 4'h0  // RULE2
        |=> cif.count == $past(cif.count) - {30'h0, $past(cif.step)})
        else $error("count down step wrong");
    AST_CNT_UP: assert property (i_ce && cif.inc && !cif.clear && cif.load_en == 4'h0  // RULE4
        |=> cif.count == $past(cif.count) + {30'h0, $past(cif.step)})
        else $error("count up step wrong");
    AST_BYTE_LOAD: assert property (i_ce && cif.load_en[0]  // RULE16
        |=> cif.count[7:0] == $past(cif.load_data))
        else $error("low byte write lost");

endmodule // dbc_counter

// *** logic/dbc_top.sv ***
/*
 * Transfer byte counter and register read data port of one DMA channel,
 * with its APB register slave and interrupt status.
 * Assumes: APB master on i_clk_sys; FIFO head data shown on i_fifo_data
 * with i_fifo_valid, advanced by one o_fifo_pop pulse; the acknowledge
 * strobe pin is asynchronous.
 */
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`include "dbc_consts.svh"

// Overview of operation
// (RULE1) Count holds any 32-bit byte length
// (RULE2) Count mode loads length, counts down
// (RULE3) Program length, then start; end when done
// (RULE4) Free-run mode counts up from value
// (RULE5) Overflow sets overflow status flag
// (RULE6) Counting continues and wraps after overflow
// (RULE7) Free-run count shows bytes transferred
// (RULE8) Software waits a cycle before reading count
// (RULE9) Software reads count bytes high first
// (RULE10) Ack-mode reads pop joined FIFO data
// (RULE11) Software sets read direction before port use
// (RULE12) Count bytes reset zero, read-write
// (RULE13) Ack-mode zero uses external strobe
// (RULE14) Direction: zero writes, one reads
// (RULE15) Clear zeroes count unless running
// (RULE16) Step by bytes moved; bytes writable alone
// (RULE17) Zero in count mode ends, sets complete
module dbc_top
    import dbc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // External acknowledge pin
    input  wire logic        i_external_ack_strobe,
    // Joined FIFO read side
    input  wire logic [15:0] i_fifo_data,
    input  wire logic        i_fifo_valid,
    output logic             o_fifo_pop,
    // Status
    output logic             o_running,
    output logic             o_irq
);
    import dbc_pkg::*;

    dbc_top_s    q;
    dbc_top_s    d;
    dbc_cnt_if   cif ();
    logic        ack_level;
    logic        acc;
    logic        done;
    logic        hit;
    logic        wr;
    logic        rd;
    logic [7:0]  idx;
    logic [31:0] rdata;
    logic        running;
    logic        ack_edge;
    logic        port_rd;
    logic        beat;
    logic        cnt_zero;
    logic [1:0]  stat_set;
    logic [1:0]  stat_clr;

    // ----------------------------------------------------------------
    // Leaf modules
    // ----------------------------------------------------------------
    dbc_sync u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_pin     (i_external_ack_strobe),
        .o_level   (ack_level)
    );

    dbc_counter u_counter (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .cif       (cif.cnt)
    );

    // ----------------------------------------------------------------
    // Address decode and read mux
    // ----------------------------------------------------------------
    // Unused address bits must be zero so aliases never answer
    always_comb
    begin
        idx   = i_paddr[9:2];
        hit   = (i_paddr[1:0] == `DBC_ADDR_LOW) && (i_paddr[11:10] == `DBC_ADDR_TOP);
        rdata = 32'h0000_0000;
        unique case (idx)
            `DBC_IDX_STAT: rdata[1:0] = q.stat;
            `DBC_IDX_MASK: rdata[1:0] = q.mask;
            `DBC_IDX_CFG:
            begin
                rdata[`DBC_CFG_FREE_RUN_SELECT] = q.free_run;
                rdata[`DBC_CFG_ACKMODE] = q.ack_mode;
                rdata[`DBC_CFG_ACTIVE]  = q.active;
            end
            `DBC_IDX_CTL:
            begin
                rdata[`DBC_CTL_RUN] = running;
                rdata[`DBC_CTL_DIR] = q.dir;                     // RULE14
            end
            `DBC_IDX_CNT3: rdata[7:0] = cif.count[31:24];        // RULE7 RULE12
            `DBC_IDX_CNT2: rdata[7:0] = cif.count[23:16];
            `DBC_IDX_CNT1: rdata[7:0] = cif.count[15:8];
            `DBC_IDX_CNT0: rdata[7:0] = cif.count[7:0];
            `DBC_IDX_RDLO: rdata[7:0] = i_fifo_data[7:0];        // RULE10
            `DBC_IDX_RDHI: rdata[7:0] = i_fifo_data[15:8];
            default:       hit = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Bus, transfer and interrupt next state
    // ----------------------------------------------------------------
    // One wait state: pready comes from a flop, so every access phase is two cycles
    always_comb
    begin
        d             = q;
        cif.load_en   = 4'h0;
        cif.load_data = i_pwdata[7:0];
        cif.clear     = 1'b0;
        cif.dec       = 1'b0;
        cif.inc       = 1'b0;
        cif.step      = 2'h0;
        stat_set      = 2'h0;
        stat_clr      = 2'h0;
        running       = (q.xfer == XFER_RUN);
        acc           = i_psel & i_penable;
        done          = acc & q.pready;
        wr            = done & i_pwrite & hit;
        rd            = done & ~i_pwrite & hit;
        cnt_zero      = (cif.count == `DBC_CNT_RST);

        // Bus answer
        d.pready  = acc & ~q.pready;
        d.pslverr = acc & ~q.pready & ~hit;
        if (acc && !q.pready)
            d.prdata = rdata;

        // Register writes
        if (wr)
        begin
            unique case (idx)
                `DBC_IDX_STAT: stat_clr = i_pwdata[1:0];
                `DBC_IDX_MASK: d.mask   = i_pwdata[1:0];
                `DBC_IDX_CFG:
                begin
                    d.free_run = i_pwdata[`DBC_CFG_FREE_RUN_SELECT];
                    d.ack_mode = i_pwdata[`DBC_CFG_ACKMODE];
                    d.active   = i_pwdata[`DBC_CFG_ACTIVE];
                end
                `DBC_IDX_CTL:
                begin
                    d.dir = i_pwdata[`DBC_CTL_DIR];              // RULE14
                    if (i_pwdata[`DBC_CTL_CLR] && !running)
                        cif.clear = 1'b1;                        // RULE15
                end
                `DBC_IDX_CNT3: cif.load_en = 4'h8;               // RULE1 RULE12 RULE16
                `DBC_IDX_CNT2: cif.load_en = 4'h4;
                `DBC_IDX_CNT1: cif.load_en = 4'h2;
                `DBC_IDX_CNT0: cif.load_en = 4'h1;
                default:       cif.load_en = 4'h0;
            endcase
        end

        // A beat is one 16-bit transfer; strobe or port read acknowledges it
        d.ack_prev = ack_level;
        ack_edge   = ack_level & ~q.ack_prev;
        port_rd    = rd & (idx == `DBC_IDX_RDHI) & q.ack_mode & q.dir;     // RULE10
        beat       = running & (q.ack_mode ? port_rd : ack_edge)           // RULE13
                     & (~q.dir | i_fifo_valid) & (q.free_run | ~cnt_zero);
        d.fifo_pop = beat & q.dir;                                         // RULE14
        if (beat)
        begin
            if (q.free_run)
            begin
                cif.inc  = 1'b1;                                 // RULE4 RULE7
                cif.step = `DBC_STEP_WORD;                       // RULE16
            end
            else
            begin
                cif.dec  = 1'b1;                                 // RULE2
                // A last odd byte moves only one, so the count never passes zero
                cif.step = (cif.count < {30'h0, `DBC_STEP_WORD}) ? cif.count[1:0] : `DBC_STEP_WORD;
            end
        end
        stat_set[`DBC_STAT_OVF] = cif.wrap;                      // RULE5 RULE6

        // Start, stop and end of count
        if (running)
        begin
            if (wr && idx == `DBC_IDX_CTL && i_pwdata[`DBC_CTL_STOP])
            begin
                d.xfer                  = XFER_IDLE;
                stat_set[`DBC_STAT_CMP] = 1'b1;
            end
            else if (!q.free_run && cnt_zero)
            begin
                d.xfer                  = XFER_IDLE;             // RULE3 RULE17
                stat_set[`DBC_STAT_CMP] = 1'b1;
            end
        end
        else if (wr && idx == `DBC_IDX_CTL && i_pwdata[`DBC_CTL_GO] && q.active)
            d.xfer = XFER_RUN;                                   // RULE3

        // Sticky status: a new event wins over a clear in the same cycle
        d.stat = (q.stat & ~stat_clr) | stat_set;
        d.irq  = |(d.stat & d.mask);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            q <= '0;
        else if (i_ce)
            q <= d;
    end

    // Outputs straight from flops
    assign o_prdata   = q.prdata;
    assign o_pready   = q.pready;
    assign o_pslverr  = q.pslverr;
    assign o_fifo_pop = q.fifo_pop;
    assign o_irq      = q.irq;
    assign o_running  = (q.xfer == XFER_RUN);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    AST_OVF_FLAG: assert property (i_ce && cif.wrap |=> q.stat[`DBC_STAT_OVF])  // RULE5
        else $error("overflow flag not set");
    AST_OVF_KEEPS_RUN: assert property (i_ce && cif.wrap && !(wr && idx == `DBC_IDX_CTL)  // RULE6
        |=> o_running)
        else $error("transfer stopped on overflow");
    AST_END_AT_ZERO: assert property (i_ce && o_running && !q.free_run && cnt_zero  // RULE17
        |=> !o_running && q.stat[`DBC_STAT_CMP])
        else $error("count mode did not end at zero");
    AST_NO_CLR_RUN: assert property (cif.clear |-> !o_running)  // RULE15
        else $error("counter cleared while running");
    AST_PORT_POP: assert property (i_ce && port_rd && o_running && i_fifo_valid  // RULE10
        && (q.free_run || !cnt_zero) |=> o_fifo_pop ##1 !o_fifo_pop)
        else $error("read port did not pop once");
    AST_STROBE_ONLY: assert property (i_ce && o_running && !q.ack_mode && (cif.dec || cif.inc)  // RULE13
        |-> ack_edge)
        else $error("count moved without strobe");
    AST_DIR_POP: assert property (o_fifo_pop |-> $past(q.dir))  // RULE14
        else $error("pop in write direction");
    AST_FREE_UP: assert property (o_running && q.free_run |-> !cif.dec)  // RULE4
        else $error("free-run counted down");
    AST_IRQ: assert property (i_ce && (q.stat & q.mask) != 2'h0 && stat_clr == 2'h0
        && !(wr && idx == `DBC_IDX_MASK) |=> o_irq)
        else $error("interrupt missing");

    COV_START: cover property (!o_running ##1 o_running);
    COV_WRAP: cover property (cif.wrap);
    COV_END: cover property (o_running && !q.free_run ##1 !o_running);
    COV_POP: cover property (o_fifo_pop);

endmodule // dbc_top

// *** testbench/dbc_fifo_model.sv ***
/*
 * Behavioural model of the FIFO area joined to the channel: it shows
 * the head word and drops it on each pop pulse.
 * Assumes: the bench fills it through push before the port reads start.
 */
`timescale 1ns/100ps

module dbc_fifo_model
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // Pop request and head word
    input  wire logic        i_pop,
    output logic      [15:0] o_data,
    output logic             o_valid
);
    logic [15:0] words[$];
    logic [15:0] last_q;

    // Bench side fill
    task automatic push(input logic [15:0] w);
        words.push_back(w);
    endtask

    // Head update; an empty FIFO shows the inverse of the last word so stale data never matches
    always @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            last_q = 16'h0;
            o_valid <= 1'b0;
            o_data  <= 16'hffff;
        end
        else
        begin
            if (i_pop && words.size() > 0)
            begin
                last_q = words.pop_front();
            end
            o_valid <= (words.size() > 0);
            o_data  <= (words.size() > 0) ? words[0] : ~last_q;
        end
    end
endmodule // dbc_fifo_model

// *** testbench/dbc_top_test.sv ***
/*
 * Self-checking bench of the byte counter block: APB master tasks,
 * register checks, count-down over the read port and free-run counting.
 * Assumes: design files and the FIFO model are compiled before it.
 */
`timescale 1ns/100ps
`include "dbc_consts.svh"

module dbc_top_test;
    import dbc_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk, rst, ce, psel, penable, pwrite, ack, pop, fvld;
    logic        pready, pslverr, running, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] fdat, w0, w1;
    int          fails, checked;

    // Clock, 40 ns period
    always #20 clk = ~clk;

    dbc_top dbc_top_inst (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_external_ack_strobe(ack), .i_fifo_data(fdat), .i_fifo_valid(fvld),
        .o_fifo_pop(pop), .o_running(running), .o_irq(irq));

    dbc_fifo_model dbc_fifo_model_inst (.i_clk_sys(clk), .i_rst(rst), .i_pop(pop), .o_data(fdat),
        .o_valid(fvld));

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic test_done();
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic tmo();
        fails++;
        $display("[ERR] %0t wait ran out", $time);
        test_done();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Expected counter after one 16-bit beat; count mode stops at zero
    function automatic logic [31:0] nxt(input logic [31:0] c, input logic up);
        if (up)
            return c + 32'h2;
        return (c > 32'h1) ? c - 32'h2 : 32'h0;
    endfunction

    // ------------------------------------------------------------
    // Bus and pin tasks
    // ------------------------------------------------------------
    // One APB transfer; pready is sampled at the rising edge where the write lands and read data is taken
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'h0, idx, 2'h0};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            tmo();
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never drives psel twice in one time step
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp, what);
    endtask

    // Counter written one byte register at a time
    task automatic cnt_wr(input logic [31:0] v);
        for (int i = 0; i < 4; i++)
            wr(`DBC_IDX_CNT3 + i[7:0], {24'h0, v[31 - 8*i -: 8]});
    endtask

    // Counter read back from the top byte down
    task automatic cnt_chk(input logic [31:0] exp);
        logic [31:0] c;
        c = 32'h0;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, `DBC_IDX_CNT3 + i[7:0], 32'h0);
            c = {c[23:0], rd[7:0]};
        end
        chk(c, exp, "count");
    endtask

    // One strobe pulse, long enough for the synchroniser
    task automatic beat();
        ack <= 1'b1;
        repeat (4) @(posedge clk);
        ack <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (running !== 1'b0 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 20)
            tmo();
        @(posedge clk);
    endtask

    // Guard against a hang anywhere
    initial
    begin
        repeat (20000) @(posedge clk);
        tmo();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] v;
        logic [31:0] e;
        clk     = 1'b0;
        rst     = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h0;
        pwdata  = 32'h0;
        ack     = 1'b0;
        ce      = 1'b1;
        fails   = 0;
        checked = 0;
        void'($urandom(70203));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values and an unmapped access
        cnt_chk(32'h0);
        apb(1'b0, 8'h50, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        // Random byte-wise loads and the all-ones length
        repeat (4)
        begin
            v = $urandom();
            cnt_wr(v);
            cnt_chk(v);
        end
        cnt_wr(32'hffff_ffff);
        cnt_chk(32'hffff_ffff);
        wr(`DBC_IDX_CTL, 32'h10);
        cnt_chk(32'h0);
        // Count mode through the read port: three bytes, the last beat moves one
        w0 = 16'($urandom());
        w1 = 16'($urandom());
        dbc_fifo_model_inst.push(w0);
        dbc_fifo_model_inst.push(w1);
        cnt_wr(32'h3);
        wr(`DBC_IDX_MASK, 32'h3);
        wr(`DBC_IDX_CFG, 32'h48);
        wr(`DBC_IDX_CTL, 32'h09);
        chk({31'h0, running}, 32'h1, "running");
        rdchk(`DBC_IDX_RDLO, {24'h0, w0[7:0]}, "port low");
        rdchk(`DBC_IDX_RDHI, {24'h0, w0[15:8]}, "port high");
        wr(`DBC_IDX_CTL, 32'h18);
        cnt_chk(nxt(32'h3, 1'b0));
        rdchk(`DBC_IDX_RDLO, {24'h0, w1[7:0]}, "port low");
        rdchk(`DBC_IDX_RDHI, {24'h0, w1[15:8]}, "port high");
        wait_idle();
        cnt_chk(32'h0);
        rdchk(`DBC_IDX_STAT, 32'h1, "complete flag");
        chk({31'h0, irq}, 32'h1, "irq raised");
        wr(`DBC_IDX_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        // Free-run over the strobe pin; a beat before go is ignored
        e = 32'hffff_fffe;
        cnt_wr(e);
        wr(`DBC_IDX_CFG, 32'h88);
        beat();
        wr(`DBC_IDX_CTL, 32'h01);
        // A strobe while the clock enable is low must be lost: all state, synchroniser too, is frozen
        ce <= 1'b0;
        beat();
        ce <= 1'b1;
        repeat (2)
        begin
            beat();
            e = nxt(e, 1'b1);
        end
        cnt_chk(e);
        chk({31'h0, running}, 32'h1, "still running");
        rdchk(`DBC_IDX_STAT, 32'h2, "overflow flag");
        chk({31'h0, irq}, 32'h1, "irq overflow");
        wr(`DBC_IDX_CTL, 32'h02);
        rdchk(`DBC_IDX_STAT, 32'h3, "stop flags");
        wr(`DBC_IDX_CTL, 32'h10);
        cnt_chk(32'h0);
        test_done();
    end
endmodule // dbc_top_test
